// ### ulx_map.vh
// register offsets, field positions, reset values and bit-time counts
`ifndef ULX_MAP_VH
`define ULX_MAP_VH
// register byte offsets
`define ULX_OFS_STATUS_TWO 8'h00
`define ULX_OFS_CONTROL_THREE 8'h04
`define ULX_OFS_MODE 8'h08
// serial_status_two fields
`define ULX_S2_LBK_FLAG 7
`define ULX_S2_EDGE_FLAG 6
`define ULX_S2_RX_INV 4
`define ULX_S2_WAKE_IDLE 3
`define ULX_S2_LONG_BRK 2
`define ULX_S2_LBK_EN 1
`define ULX_S2_RX_ACTIVE 0
// serial_control_three fields
`define ULX_C3_RX_NINTH 7
`define ULX_C3_TX_NINTH 6
`define ULX_C3_DIR 5
`define ULX_C3_TX_INV 4
`define ULX_C3_OR_IE 3
`define ULX_C3_NF_IE 2
`define ULX_C3_FE_IE 1
`define ULX_C3_PF_IE 0
// mode register fields
`define ULX_MD_NINE_BIT 0
`define ULX_MD_LOOP 1
`define ULX_MD_RX_SRC 2
`define ULX_MD_STANDBY 3
// reset values
`define ULX_S2_RST 8'h00
`define ULX_C3_RST 8'h00
`define ULX_MD_RST 8'h00
// break lengths in bit times, eight-bit mode; nine-bit adds one
`define ULX_BRK_TX_SHORT 4'hA
`define ULX_BRK_TX_LONG 4'hD
`define ULX_BRK_DET_NORM 4'hA
`define ULX_BRK_DET_LIN 4'hB
// bus responses
`define ULX_RESP_OKAY 2'h0
`define ULX_RESP_SLVERR 2'h2
`endif

// ### ulx_sync2.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ulx_sync2 #(
    parameter W = 2
) (
    input wire clk,
    input wire resetn,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    // first stage feeds the second stage only
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // idle lines rest high, so reset to ones
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= {W{1'b1}};
            sync_q <= {W{1'b1}};
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // ulx_sync2

// ### ulx_bit_counter.v
// saturating bit-time counter with a compare limit
`timescale 1ns/100ps
module ulx_bit_counter #(
    parameter W = 4
) (
    input wire clk,
    input wire resetn,
    input wire clear,
    input wire tick,
    input wire [W-1:0] limit,
    output wire reached
);
    reg [W-1:0] count_q; // bit times counted so far

    assign reached = (count_q >= limit);

    // count ticks up to the limit, then hold so it never wraps
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= {W{1'b0}};
        end else if (clear) begin
            count_q <= {W{1'b0}};
        end else if (tick && !reached) begin
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // ulx_bit_counter

// ### ulx_status_ctl.v
// extended serial status/control block with an axi4-lite register slave
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ulx_map.vh"

module ulx_status_ctl #(
    parameter AW = 8
) (
    input wire clk,
    input wire resetn,
    // axi4-lite slave
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // pins
    input wire rx_pin,
    input wire txd_pin_in,
    output wire txd_pin_out,
    output wire txd_pin_oe_n,
    // baud generator and shifters of the core
    input wire bit_tick,
    input wire rx_start_valid,
    input wire rx_idle_detect,
    input wire rx_char_done,
    input wire rx_frame_err,
    input wire rx_ninth_in,
    input wire tx_load,
    input wire [7:0] tx_byte,
    input wire tx_serial,
    input wire tx_break_req,
    input wire overrun_flag,
    input wire noise_flag,
    input wire framing_error,
    input wire parity_error_flag,
    output wire rx_line,
    output wire nine_bit_mode,
    output wire idle_set,
    output wire framing_set,
    output wire receive_full_set,
    output wire [8:0] tx_shift_data,
    output wire tx_shift_load,
    output wire tx_break_active,
    output wire overrun_irq,
    output wire noise_irq,
    output wire framing_irq,
    output wire parity_irq
);
    // software registers
    reg [7:0] s2_q; // serial_status_two storage
    reg [7:0] c3_q; // serial_control_three storage
    reg [7:0] md_q; // mode register
    // bus slave state
    reg aw_held_q;
    reg w_held_q;
    reg [AW-1:0] aw_addr_q;
    reg [7:0] w_byte_q;
    reg w_strb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    // datapath flops feeding outputs
    reg rx_line_q;
    reg edge_prev_q;
    reg det_prev_q;
    reg brk_tx_q;
    reg txd_out_q;
    reg txd_oe_n_q;
    reg idle_set_q;
    reg framing_set_q;
    reg full_set_q;
    reg [8:0] tx_data_q;
    reg tx_load_q;
    reg [3:0] irq_q;

    // field aliases
    wire lbk_en = s2_q[`ULX_S2_LBK_EN];
    wire rx_inv = s2_q[`ULX_S2_RX_INV];
    wire wake_idle = s2_q[`ULX_S2_WAKE_IDLE];
    wire long_brk = s2_q[`ULX_S2_LONG_BRK];
    wire tx_inv = c3_q[`ULX_C3_TX_INV];
    wire nine_bit = md_q[`ULX_MD_NINE_BIT];
    wire loop_sel = md_q[`ULX_MD_LOOP];
    wire rx_src_sel = md_q[`ULX_MD_RX_SRC];
    wire standby = md_q[`ULX_MD_STANDBY];
    wire single_wire = loop_sel & rx_src_sel;

    // synchronised pins
    wire [1:0] pins_s;
    wire rx_pin_s = pins_s[0];
    wire txd_in_s = pins_s[1];

    ulx_sync2 #(.W(2)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({txd_pin_in, rx_pin}),
        .q(pins_s)
    );

    // write transaction fires once both halves are held
    wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    wire rd_fire = s_axi_arvalid & ~rvalid_q;
    wire wr_s2 = wr_fire & w_strb_q & (aw_addr_q == `ULX_OFS_STATUS_TWO);
    wire wr_c3 = wr_fire & w_strb_q & (aw_addr_q == `ULX_OFS_CONTROL_THREE);
    wire wr_md = wr_fire & w_strb_q & (aw_addr_q == `ULX_OFS_MODE);
    wire wr_hit = (aw_addr_q == `ULX_OFS_STATUS_TWO) |
                  (aw_addr_q == `ULX_OFS_CONTROL_THREE) |
                  (aw_addr_q == `ULX_OFS_MODE);

    assign s_axi_awready = ~aw_held_q;
    assign s_axi_wready = ~w_held_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // address and data channels are taken in either order
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= {AW{1'b0}};
            w_byte_q <= 8'h00;
            w_strb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `ULX_RESP_OKAY;
        end else begin
            // capture address when free
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            // only byte lane zero carries register bits
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            // response after both halves, channels then reopen
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `ULX_RESP_OKAY : `ULX_RESP_SLVERR;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read data is latched at the address handshake
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `ULX_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= `ULX_RESP_OKAY;
            case (s_axi_araddr)
                `ULX_OFS_STATUS_TWO: rdata_q <= {24'h000000, s2_q};
                `ULX_OFS_CONTROL_THREE: rdata_q <= {24'h000000, c3_q};
                `ULX_OFS_MODE: rdata_q <= {24'h000000, md_q};
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= `ULX_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // receive source: own pin, shared tx pin, or internal loop
    wire tx_line = brk_tx_q ? 1'b0 : tx_serial;
    wire rx_src = single_wire ? txd_in_s : (loop_sel ? tx_line : rx_pin_s);

    // active edge seen on the pin after inversion
    wire pin_lvl = rx_pin_s ^ rx_inv;
    wire edge_hit = edge_prev_q & ~pin_lvl;

    // break detection counts low bit times on the receive line
    wire [3:0] det_base = lbk_en ? `ULX_BRK_DET_LIN : `ULX_BRK_DET_NORM;
    wire [3:0] det_limit = det_base + {3'h0, nine_bit};
    wire det_reached;
    wire brk_found = det_reached & ~det_prev_q;

    // threshold by lin enable and mode
    ulx_bit_counter #(.W(4)) u_brk_det (
        .clk(clk),
        .resetn(resetn),
        .clear(rx_line_q),
        .tick(bit_tick),
        .limit(det_limit),
        .reached(det_reached)
    );

    // transmit break length from long-break select and mode
    wire [3:0] tx_base = long_brk ? `ULX_BRK_TX_LONG : `ULX_BRK_TX_SHORT;
    wire [3:0] tx_limit = tx_base + {3'h0, nine_bit};
    wire tx_reached;

    ulx_bit_counter #(.W(4)) u_brk_tx (
        .clk(clk),
        .resetn(resetn),
        .clear(~brk_tx_q),
        .tick(bit_tick),
        .limit(tx_limit),
        .reached(tx_reached)
    );

    // status_two: flags set by hardware win over software clears
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s2_q <= `ULX_S2_RST;
        end else begin
            if (wr_s2) begin
                // writable control bits; bit five stays zero
                s2_q[4:1] <= w_byte_q[4:1];
            end
            // set on break with lin enabled
            if (brk_found && lbk_en) begin
                s2_q[`ULX_S2_LBK_FLAG] <= 1'b1;
            end else if (wr_s2 && w_byte_q[`ULX_S2_LBK_FLAG]) begin
                s2_q[`ULX_S2_LBK_FLAG] <= 1'b0;
            end
            if (edge_hit) begin
                s2_q[`ULX_S2_EDGE_FLAG] <= 1'b1;
            end else if (wr_s2 && w_byte_q[`ULX_S2_EDGE_FLAG]) begin
                s2_q[`ULX_S2_EDGE_FLAG] <= 1'b0;
            end
            if (rx_start_valid) begin
                s2_q[`ULX_S2_RX_ACTIVE] <= 1'b1;
            end else if (rx_idle_detect) begin
                s2_q[`ULX_S2_RX_ACTIVE] <= 1'b0;
            end
            s2_q[5] <= 1'b0;
        end
    end

    // control_three: ninth receive bit is read-only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c3_q <= `ULX_C3_RST;
        end else begin
            if (wr_c3) begin
                c3_q[6:0] <= w_byte_q[6:0];
            end
            // ninth bit captured with the byte
            if (rx_char_done && !lbk_en) begin
                c3_q[`ULX_C3_RX_NINTH] <= nine_bit & rx_ninth_in;
            end
        end
    end

    // mode register; standby is left by hardware on an idle wake
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            md_q <= `ULX_MD_RST;
        end else begin
            if (wr_md) begin
                md_q[3:0] <= w_byte_q[3:0];
            end
            if (standby && rx_idle_detect) begin
                md_q[`ULX_MD_STANDBY] <= 1'b0;
            end
        end
    end

    // receive path and edge history
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_line_q <= 1'b1;
            edge_prev_q <= 1'b1;
            det_prev_q <= 1'b0;
        end else begin
            // idle high line, start bit reads low
            // inversion on the line all users see
            rx_line_q <= rx_src ^ rx_inv;
            edge_prev_q <= pin_lvl;
            det_prev_q <= det_reached;
        end
    end

    // gated receive events toward the core
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_set_q <= 1'b0;
            framing_set_q <= 1'b0;
            full_set_q <= 1'b0;
        end else begin
            // standby idle needs wake idle detect
            idle_set_q <= rx_idle_detect & (~standby | wake_idle);
            // lin detect holds back both flags
            framing_set_q <= rx_char_done & rx_frame_err & ~lbk_en;
            full_set_q <= rx_char_done & ~lbk_en;
        end
    end

    // transmit side: break timing, shifter load, pin drive
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            brk_tx_q <= 1'b0;
            tx_data_q <= 9'h000;
            tx_load_q <= 1'b0;
            txd_out_q <= 1'b1;
            txd_oe_n_q <= 1'b0;
        end else begin
            // break ends once the selected length has passed
            if (!brk_tx_q && tx_break_req) begin
                brk_tx_q <= 1'b1;
            end else if (brk_tx_q && tx_reached) begin
                brk_tx_q <= 1'b0;
            end
            // ninth bit joins byte as one value
            // nine bits only in nine-bit mode
            tx_load_q <= tx_load;
            if (tx_load) begin
                tx_data_q <= {nine_bit & c3_q[`ULX_C3_TX_NINTH], tx_byte};
            end
            // inversion covers break and idle too
            txd_out_q <= tx_line ^ tx_inv;
            txd_oe_n_q <= single_wire & ~c3_q[`ULX_C3_DIR];
        end
    end

    // interrupt requests follow flag and enable levels
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 4'h0;
        end else begin
            irq_q[3] <= overrun_flag & c3_q[`ULX_C3_OR_IE];
            irq_q[2] <= noise_flag & c3_q[`ULX_C3_NF_IE];
            irq_q[1] <= framing_error & c3_q[`ULX_C3_FE_IE];
            irq_q[0] <= parity_error_flag & c3_q[`ULX_C3_PF_IE];
        end
    end

    // output hookup
    assign rx_line = rx_line_q;
    assign nine_bit_mode = md_q[`ULX_MD_NINE_BIT];
    assign idle_set = idle_set_q;
    assign framing_set = framing_set_q;
    assign receive_full_set = full_set_q;
    assign tx_shift_data = tx_data_q;
    assign tx_shift_load = tx_load_q;
    assign tx_break_active = brk_tx_q;
    assign txd_pin_out = txd_out_q;
    assign txd_pin_oe_n = txd_oe_n_q;
    assign overrun_irq = irq_q[3];
    assign noise_irq = irq_q[2];
    assign framing_irq = irq_q[1];
    assign parity_irq = irq_q[0];
endmodule // ulx_status_ctl

// ### ulx_status_ctl_chk.sv
// assertion checker for the extended serial status and control block
`timescale 1ns/100ps
module ulx_status_ctl_chk (
    input logic clk,
    input logic resetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic tx_load,
    input logic [7:0] tx_byte,
    input logic tx_shift_load,
    input logic [8:0] tx_shift_data,
    input logic tx_break_req,
    input logic tx_break_active,
    input logic rx_char_done,
    input logic rx_frame_err,
    input logic rx_idle_detect,
    input logic framing_set,
    input logic receive_full_set,
    input logic idle_set,
    input logic overrun_flag,
    input logic overrun_irq,
    input logic noise_flag,
    input logic noise_irq
);
    // one clock domain, so one clocking and one reset guard serve all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a taken address must not be taken again in the cycle after
    aw_taken_hold_a: assert property (s_axi_awvalid && s_axi_awready
        |=> !s_axi_awready) else $error("write address taken twice");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    // read data must stand until the master takes it
    r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    b_stand_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response dropped");
    tx_load_byte_a: assert property (tx_load |=> tx_shift_load &&
        tx_shift_data[7:0] == $past(tx_byte)) else $error("shift load bad");
    shift_cause_a: assert property (tx_shift_load |->
        $past(tx_load)) else $error("shift load without request");
    brk_start_a: assert property (tx_break_req && !tx_break_active
        |=> tx_break_active) else $error("break did not start");
    frame_cause_a: assert property (framing_set |->
        $past(rx_char_done && rx_frame_err)) else $error("stray framing");
    full_cause_a: assert property (receive_full_set |->
        $past(rx_char_done)) else $error("stray full event");
    idle_cause_a: assert property (idle_set |->
        $past(rx_idle_detect)) else $error("stray idle event");
    or_irq_a: assert property (overrun_irq |->
        $past(overrun_flag)) else $error("overrun irq without flag");
    nf_irq_a: assert property (!noise_flag |=>
        !noise_irq) else $error("noise irq without flag");
    cover property ($rose(tx_break_active));
    cover property (framing_set);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ulx_status_ctl_chk

bind ulx_status_ctl ulx_status_ctl_chk chk (.*);

// ### ulx_remote_node.sv
// behavioural remote node that holds the receive line low for n bit times
`timescale 1ns/100ps
module ulx_remote_node (
    input logic clk,
    input logic resetn,
    input logic bit_tick,
    input logic go,
    input logic [4:0] nlow,
    output logic rx_pin,
    output logic busy
);
    logic armed_q; // waiting for a tick so low periods align to bit times
    logic [4:0] cnt_q; // bit times spent low so far
    assign busy = armed_q | ~rx_pin;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_pin <= 1'b1;
            armed_q <= 1'b0;
            cnt_q <= 5'h00;
        end else if (go) begin
            armed_q <= 1'b1;
        end else if (armed_q && bit_tick) begin
            armed_q <= 1'b0;
            rx_pin <= 1'b0;
            cnt_q <= 5'h00;
        end else if (!rx_pin && bit_tick) begin
            cnt_q <= cnt_q + 5'h01;
            // back to idle high once the count is spent
            if (cnt_q + 5'h01 == nlow) rx_pin <= 1'b1;
        end
    end
endmodule // ulx_remote_node

// ### ulx_status_ctl_tb_top.sv
// self-checking bench for the extended serial status and control block
`timescale 1ns/100ps
`include "ulx_map.vh"
`define CK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ulx_status_ctl_tb_top;
    logic clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, bit_tick, tx_serial;
    logic rx_start_valid, rx_idle_detect, rx_char_done, rx_frame_err;
    logic rx_ninth_in, tx_load, tx_break_req, overrun_flag;
    logic noise_flag, framing_error, parity_error_flag, node_go;
    logic [7:0] s_axi_awaddr, s_axi_araddr, tx_byte, rd_d, st;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb, en;
    logic [4:0] node_len;
    logic [2:0] o; // sampled idle, framing, full events
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, rx_pin, txd_pin_in, node_busy, txd_pin_out;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire txd_pin_oe_n, rx_line, nine_bit_mode, idle_set, framing_set;
    wire receive_full_set, tx_shift_load, tx_break_active;
    wire [8:0] tx_shift_data;
    wire overrun_irq, noise_irq, framing_irq, parity_irq;
    int fails = 0, compares = 0, cyc = 0;
    // single wire pulled high whenever the block lets go of it
    assign txd_pin_in = txd_pin_oe_n ? 1'b1 : txd_pin_out;
    ulx_status_ctl #(.AW(8)) DUT (.*);
    ulx_remote_node node_u (.clk(clk), .resetn(resetn),
        .bit_tick(bit_tick), .go(node_go), .nlow(node_len),
        .rx_pin(rx_pin), .busy(node_busy));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // one bit time is eight clocks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        bit_tick <= (cyc % 8 == 7);
    end
    function [7:0] nx(input [7:0] s);
        nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [4:0] brk_len(input lng, input nine);
        brk_len = (lng ? 5'h0D : 5'h0A) + {4'h0, nine};
    endfunction
    task summarize; begin
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end endtask
    // bus write: hold each channel until its own ready
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge clk);
        s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end endtask
    task rd(input [7:0] a); begin
        @(posedge clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata[7:0]; resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end endtask
    // one-cycle core events {start, idle, done}, outputs sampled after
    task ev(input [2:0] e); begin
        @(posedge clk); {rx_start_valid, rx_idle_detect, rx_char_done} <= e;
        @(posedge clk); {rx_start_valid, rx_idle_detect, rx_char_done} <= 0;
        @(posedge clk); o = {idle_set, framing_set, receive_full_set};
    end endtask
    task node_go_t(input [4:0] n); begin
        @(posedge clk); node_go <= 1'b1; node_len <= n;
        @(posedge clk); node_go <= 1'b0;
        @(posedge clk);
    end endtask
    task node_end; begin
        while (node_busy) @(posedge clk);
        repeat (4) @(posedge clk);
    end endtask
    // mode {invert, long, nine}: send one break, count its bit times
    task brk(input [2:0] m); int n; logic t; begin
        wr(8'h08, {7'h0, m[0]});
        wr(8'h00, {5'h0, m[1], 2'h0});
        wr(8'h04, {3'h0, m[2], 4'h0});
        @(posedge clk); tx_break_req <= 1'b1;
        @(posedge clk); tx_break_req <= 1'b0;
        while (!tx_break_active) @(posedge clk);
        n = 0;
        while (tx_break_active) begin
            if (bit_tick) begin n++; t = txd_pin_out; end
            @(posedge clk);
        end
        `CK(n[4:0], brk_len(m[1], m[0]))
        `CK(t, m[2])
    end endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize;
    end
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, node_go, tx_load} = 0;
        {rx_start_valid, rx_idle_detect, rx_char_done, rx_frame_err} = 0;
        {rx_ninth_in, tx_break_req, overrun_flag, noise_flag} = 0;
        {framing_error, parity_error_flag, node_len, tx_byte} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hF; tx_serial = 1'b1; st = 8'h19;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        // reset values, then the unmapped slot refuses
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4));
            `CK(rd_d, 8'h00)
            `CK(resp, (i == 3) ? `ULX_RESP_SLVERR : `ULX_RESP_OKAY)
        end
        wr(8'h0C, 8'hFF);
        `CK(resp, `ULX_RESP_SLVERR)
        wr(8'h00, 8'hEE); rd(8'h00);
        `CK(rd_d, 8'h0E)
        // lin detection threshold chosen before listening for breaks
        wr(8'h00, 8'h02);
        node_go_t(5'h0A); node_end; rd(8'h00);
        `CK(rd_d, 8'h42)
        node_go_t(5'h0B); node_end; rd(8'h00);
        `CK(rd_d, 8'hC2)
        wr(8'h00, 8'hC2); rd(8'h00);
        `CK(rd_d, 8'h02)
        // inverted receive: only the rising pin edge counts
        wr(8'h00, 8'h10); wr(8'h00, 8'hD0);
        node_go_t(5'h0A); repeat (30) @(posedge clk);
        `CK(rx_line, 1'b1)
        rd(8'h00);
        `CK(rd_d[6], 1'b0)
        node_end; rd(8'h00);
        `CK(rd_d[6], 1'b1)
        // lin detection hides framing and full events
        wr(8'h08, 8'h01); wr(8'h00, 8'h02);
        rx_frame_err <= 1'b1; rx_ninth_in <= 1'b1;
        ev(3'h1);
        `CK(o[1:0], 2'h0)
        wr(8'h00, 8'h00); ev(3'h1);
        `CK(o[1:0], 2'h3)
        // ninth bit read on its own
        rd(8'h04);
        `CK(rd_d[7], 1'b1)
        `CK(nine_bit_mode, 1'b1)
        ev(3'h4); rd(8'h00);
        `CK(rd_d[0], 1'b1)
        ev(3'h2); rd(8'h00);
        `CK(rd_d[0], 1'b0)
        for (int i = 0; i < 2; i++) begin
            wr(8'h08, 8'h08); wr(8'h00, 8'(i * 8)); ev(3'h2);
            `CK(o[2], i[0])
        end
        for (int i = 0; i < 8; i++) brk(3'(i));
        // ninth transmit bit travels with a random byte
        for (int i = 0; i < 4; i++) begin
            st = nx(st); wr(8'h04, {1'b0, st[0], 6'h0});
            @(posedge clk); tx_byte <= st; tx_load <= 1'b1;
            @(posedge clk); tx_load <= 1'b0;
            @(posedge clk);
            `CK(tx_shift_data, {st[0], st})
        end
        // direction bit matters only in single-wire mode
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, i[1] ? 8'h06 : 8'h00); wr(8'h04, {2'h0, i[0], 5'h0});
            repeat (2) @(posedge clk);
            `CK(txd_pin_oe_n, i[1] & ~i[0])
        end
        for (int i = 0; i < 8; i++) begin
            st = nx(st); en = st[3:0]; wr(8'h04, {4'h0, en}); st = nx(st);
            @(posedge clk);
            {overrun_flag, noise_flag, framing_error, parity_error_flag} <=
                st[3:0];
            repeat (3) @(posedge clk);
            `CK({overrun_irq, noise_irq, framing_irq, parity_irq}, st[3:0] & en)
        end
        summarize;
    end
endmodule // ulx_status_ctl_tb_top
